// ### dv/code_space_region_decoder_tb.sv
// self-checking bench for the code-space region decoder
module code_space_region_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0, arst_n = 1'b0;
    logic [11:0] ramAddr = 12'h000;
    logic        ramWrEn = 1'b0;
    logic [7:0]  ramWrData = 8'h00, ramRdData;
    logic        ramHit, protRegionValid, readBypassProt, readOnlyArea;
    logic [1:0]  bootAreaSizeField = 2'h0;
    logic        lowVoltageProgEnable = 1'b0, lowVoltageModeInput = 1'b0;
    logic        ptrStepInc = 1'b0, ptrStepDec = 1'b0, ptrStepByTwo = 1'b0;
    logic        masterClearProgVoltage, programmingClock, programmingData;
    logic [21:0] tableAddr;
    logic [2:0]  blockIndex;
    logic        lowVoltageModeActive, frameValid, coreInstrValid;
    logic [3:0]  frameCmd;
    logic [15:0] frameOperand;
    logic [31:0] seed = 32'h623C;
    code_space_pkg::region_t region;
    int          num_errors = 0, checks = 0, frames = 0, cores = 0;

    always #2.5 clk = ~clk;

    code_space_region_decoder u_dut (
        .clk, .arst_n, .ramAddr, .ramWrEn, .ramWrData, .ramRdData, .ramHit,
        .ptrStepInc, .ptrStepDec, .ptrStepByTwo,
        .bootAreaSizeField, .lowVoltageProgEnable, .masterClearProgVoltage,
        .lowVoltageModeInput, .programmingClock, .programmingData,
        .tableAddr, .region, .blockIndex, .protRegionValid, .readBypassProt,
        .readOnlyArea, .lowVoltageModeActive, .frameValid, .frameCmd,
        .frameOperand, .coreInstrValid);

    serial_programmer_model u_prog (
        .clk, .masterClearProgVoltage, .programmingClock, .programmingData);

    always @(posedge clk) begin
        if (frameValid === 1'b1) frames++;
        if (coreInstrValid === 1'b1) cores++;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // flags {readOnly, bypass, prot}, block, region
    function automatic logic [11:0] exp_dec(input logic [21:0] a,
                                            input logic [1:0]  f);
        if (a <= (f[0] ? 22'h000FFF : 22'h0007FF)) return 12'h201;
        if (a <= 22'h00FFFF) return {3'h1, a[16:14], 6'h02};
        if (a >= 22'h200000 && a <= 22'h200007) return 12'h404;
        if (a >= 22'h300000 && a <= 22'h30000D) return 12'h408;
        if (a >= 22'h3FFFFE) return 12'hC10;
        return 12'h020;
    endfunction : exp_dec

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        ramAddr   <= a;
        ramWrEn   <= 1'b1;
        ramWrData <= d;
        @(posedge clk);
        ramWrEn   <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        ramAddr <= a;
        repeat (2) @(posedge clk);
        #1;
        chk({ramHit, ramRdData}, {a >= 12'hFF6 && a <= 12'hFF8, e});
    endtask : rd

    task automatic probe(input logic [21:0] a, input logic [1:0] f);
        @(posedge clk);
        bootAreaSizeField <= f;
        wr(12'hFF8, {2'h0, a[21:16]});
        wr(12'hFF7, a[15:8]);
        wr(12'hFF6, a[7:0]);
        repeat (2) @(posedge clk);
        #1;
        chk(tableAddr, a);
        chk({readOnlyArea, readBypassProt, protRegionValid, blockIndex,
             region}, exp_dec(a, f));
    endtask : probe

    // one-cycle pointer step, then compare the stepped address
    task automatic step(input logic i, input logic d, input logic t,
                        input logic [21:0] e);
        @(posedge clk);
        ptrStepInc   <= i;
        ptrStepDec   <= d;
        ptrStepByTwo <= t;
        @(posedge clk);
        ptrStepInc   <= 1'b0;
        ptrStepDec   <= 1'b0;
        #1;
        chk(tableAddr, e);
    endtask : step

    task automatic finish_test();
        if (num_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    initial begin : main
        logic [31:0] r;
        static logic [21:0] cor [20] = '{22'h0, 22'h7FF, 22'h800, 22'hFFF,
            22'h1000, 22'h3FFF, 22'h4000, 22'hFFFF, 22'h10000, 22'h1FFFFF,
            22'h200000, 22'h200007, 22'h200008, 22'h2FFFFF, 22'h300000,
            22'h30000D, 22'h30000E, 22'h3FFFFD, 22'h3FFFFE, 22'h3FFFFF};
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        wr(12'hFF8, 8'hFF);
        rd(12'hFF8, 8'h3F);
        rd(12'hFF5, 8'h00);
        rd(12'hFF9, 8'h00);
        foreach (cor[i]) for (int f = 0; f < 4; f++) probe(cor[i], 2'(f));
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            probe(r[31] ? {5'h00, r[16:0]} : r[21:0], r[23:22]);
        end
        // carry across all bytes, inc priority, wrap below zero
        probe(22'h00FFFF, 2'h0);
        step(1'b1, 1'b0, 1'b0, 22'h010000);
        step(1'b0, 1'b1, 1'b1, 22'h00FFFE);
        step(1'b1, 1'b1, 1'b1, 22'h010000);
        probe(22'h000000, 2'h0);
        step(1'b0, 1'b1, 1'b0, 22'h3FFFFF);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            lowVoltageProgEnable <= i[0];
            lowVoltageModeInput  <= i[1];
            repeat (4) @(posedge clk);
            #1;
            chk(lowVoltageModeActive, i[0] & i[1]);
        end
        u_prog.set_mode(1'b1);
        u_prog.send({r[15:0], 4'h0}, 20);
        chk({frameCmd, frameOperand}, {4'h0, r[15:0]});
        u_prog.send(20'hFFFFF, 9);
        u_prog.set_mode(1'b0);
        u_prog.set_mode(1'b1);
        u_prog.send({r[31:16], 4'hD}, 20);
        chk({frameCmd, frameOperand}, {4'hD, r[31:16]});
        chk(frames, 2);
        chk(cores, 1);
        finish_test();
    end

    initial begin : watchdog
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule : code_space_region_decoder_tb

// ### dv/serial_programmer_model.sv
// serial programmer model driving the programming pins
module serial_programmer_model (
    // clock
    input  wire logic clk,
    // programming pins
    output logic      masterClearProgVoltage,
    output logic      programmingClock,
    output logic      programmingData
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        masterClearProgVoltage = 1'b0;
        programmingClock       = 1'b0;
        programmingData        = 1'b0;
    end

    task automatic set_mode(input logic on);
        @(posedge clk);
        masterClearProgVoltage <= on;
        repeat (6) @(posedge clk);
    endtask : set_mode

    task automatic send(input logic [19:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            programmingClock <= 1'b1;
            programmingData  <= w[i];
            repeat (4) @(posedge clk);
            programmingClock <= 1'b0;
            repeat (3) @(posedge clk);
        end
        // released data line must not look held
        @(posedge clk);
        programmingData <= ~programmingData;
        repeat (6) @(posedge clk);
    endtask : send
endmodule : serial_programmer_model

// ### include/code_space_pkg.sv
// constants and types for the table-pointer code-space decoder
package code_space_pkg;

    // ------------------------------------------------------------------
    // pointer and data-RAM layout
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 22;
    localparam int          RAM_ADDR_W      = 12;
    localparam int          UPPER_USED_W    = 6;
    localparam logic [11:0] PTR_UPPER_OFS   = 12'hFF8;
    localparam logic [11:0] PTR_HIGH_OFS    = 12'hFF7;
    localparam logic [11:0] PTR_LOW_OFS     = 12'hFF6;
    localparam logic [7:0]  PTR_BYTE_RESET  = 8'h00;

    // ------------------------------------------------------------------
    // fixed areas outside code memory
    // ------------------------------------------------------------------
    localparam logic [21:0] USER_ID_FIRST   = 22'h200000;
    localparam logic [21:0] USER_ID_LAST    = 22'h200007;
    localparam logic [21:0] CONFIG_FIRST    = 22'h300000;
    localparam logic [21:0] CONFIG_LAST     = 22'h30000D;
    localparam logic [21:0] DEVICE_ID_FIRST = 22'h3FFFFE;
    localparam logic [21:0] DEVICE_ID_LAST  = 22'h3FFFFF;

    // ------------------------------------------------------------------
    // code-space sizes, last byte address of each variant
    // ------------------------------------------------------------------
    localparam logic [21:0] CODE_END_64K    = 22'h00FFFF;
    localparam logic [21:0] CODE_END_48K    = 22'h00BFFF;
    localparam logic [21:0] CODE_END_96K    = 22'h017FFF;
    localparam logic [21:0] CODE_END_80K    = 22'h013FFF;
    localparam logic [21:0] CODE_END_32K    = 22'h007FFF;
    localparam logic [21:0] CODE_END_24K    = 22'h005FFF;
    localparam logic [21:0] CODE_END_16K    = 22'h003FFF;
    localparam logic [21:0] CODE_END_8K     = 22'h001FFF;
    localparam logic [21:0] CODE_END_4K     = 22'h000FFF;

    // block sizes as shift counts: 16K, 8K, 4K bytes
    localparam logic [4:0]  SHIFT_16K       = 5'h0E;
    localparam logic [4:0]  SHIFT_8K        = 5'h0D;
    localparam logic [4:0]  SHIFT_4K        = 5'h0C;

    // boot-area last byte addresses
    localparam logic [21:0] BOOT_END_256W   = 22'h0001FF;
    localparam logic [21:0] BOOT_END_512W   = 22'h0003FF;
    localparam logic [21:0] BOOT_END_1KW    = 22'h0007FF;
    localparam logic [21:0] BOOT_END_2KW    = 22'h000FFF;

    // ------------------------------------------------------------------
    // serial command framing
    // ------------------------------------------------------------------
    localparam int          CMD_W           = 4;
    localparam int          OPERAND_W       = 16;
    localparam int          FRAME_W         = 20;
    localparam logic [4:0]  FRAME_LAST_BIT  = 5'h13;
    localparam logic [3:0]  CMD_CORE_INSTR  = 4'h0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        VAR_64K, VAR_48K, VAR_96K, VAR_80K, VAR_32K_8K, VAR_24K,
        VAR_16K_8K, VAR_16K_16K, VAR_32K_16K, VAR_4K, VAR_8K
    } variant_t;

    typedef enum logic [5:0] {
        REG_BOOT      = 6'h01,
        REG_CODE      = 6'h02,
        REG_USER_ID   = 6'h04,
        REG_CONFIG    = 6'h08,
        REG_DEVICE_ID = 6'h10,
        REG_UNIMPL    = 6'h20
    } region_t;

endpackage : code_space_pkg

// ### rtl/code_space_region_decoder.sv
// table-pointer registers, region decoder and serial frame receiver
module code_space_region_decoder #(
    parameter code_space_pkg::variant_t VARIANT = code_space_pkg::VAR_64K
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    // data RAM access to the pointer bytes
    input  wire logic [11:0]                ramAddr,
    input  wire logic                       ramWrEn,
    input  wire logic [7:0]                 ramWrData,
    output logic      [7:0]                 ramRdData,
    output logic                            ramHit,
    // pointer steps from the table engine
    input  wire logic                       ptrStepInc,
    input  wire logic                       ptrStepDec,
    input  wire logic                       ptrStepByTwo,
    // configuration bits
    input  wire logic [1:0]                 bootAreaSizeField,
    input  wire logic                       lowVoltageProgEnable,
    // programming pins
    input  wire logic                       masterClearProgVoltage,
    input  wire logic                       lowVoltageModeInput,
    input  wire logic                       programmingClock,
    input  wire logic                       programmingData,
    // decode result
    output logic      [21:0]                tableAddr,
    output code_space_pkg::region_t         region,
    output logic      [2:0]                 blockIndex,
    output logic                            protRegionValid,
    output logic                            readBypassProt,
    output logic                            readOnlyArea,
    // low-voltage mode and serial frame result
    output logic                            lowVoltageModeActive,
    output logic                            frameValid,
    output logic      [3:0]                 frameCmd,
    output logic      [15:0]                frameOperand,
    output logic                            coreInstrValid
);

    // ------------------------------------------------------------------
    // variant lookups
    // ------------------------------------------------------------------
    // sizes per variant
    function automatic logic [21:0] codeEnd(
        input code_space_pkg::variant_t v);
        case (v)
            code_space_pkg::VAR_64K:     codeEnd = code_space_pkg::CODE_END_64K;
            code_space_pkg::VAR_48K:     codeEnd = code_space_pkg::CODE_END_48K;
            code_space_pkg::VAR_96K:     codeEnd = code_space_pkg::CODE_END_96K;
            code_space_pkg::VAR_80K:     codeEnd = code_space_pkg::CODE_END_80K;
            code_space_pkg::VAR_32K_8K,
            code_space_pkg::VAR_32K_16K: codeEnd = code_space_pkg::CODE_END_32K;
            code_space_pkg::VAR_24K:     codeEnd = code_space_pkg::CODE_END_24K;
            code_space_pkg::VAR_16K_8K,
            code_space_pkg::VAR_16K_16K: codeEnd = code_space_pkg::CODE_END_16K;
            code_space_pkg::VAR_8K:      codeEnd = code_space_pkg::CODE_END_8K;
            code_space_pkg::VAR_4K:      codeEnd = code_space_pkg::CODE_END_4K;
            default:                     codeEnd = code_space_pkg::CODE_END_4K;
        endcase
    endfunction : codeEnd

    function automatic logic [4:0] blockShift(
        input code_space_pkg::variant_t v);
        case (v)
            code_space_pkg::VAR_32K_8K,
            code_space_pkg::VAR_24K,
            code_space_pkg::VAR_16K_8K:  blockShift = code_space_pkg::SHIFT_8K;
            code_space_pkg::VAR_4K,
            code_space_pkg::VAR_8K:      blockShift = code_space_pkg::SHIFT_4K;
            default:                     blockShift = code_space_pkg::SHIFT_16K;
        endcase
    endfunction : blockShift

    // boot-area last byte for a variant and size field
    function automatic logic [21:0] bootEnd(
        input code_space_pkg::variant_t v,
        input logic [1:0]               f);
        case (v)
            code_space_pkg::VAR_32K_8K,
            code_space_pkg::VAR_24K:    bootEnd = code_space_pkg::BOOT_END_1KW;
            code_space_pkg::VAR_16K_8K: bootEnd = code_space_pkg::BOOT_END_512W;
            code_space_pkg::VAR_4K,
            code_space_pkg::VAR_8K: begin
                case (f)
                    2'h0:    bootEnd = code_space_pkg::BOOT_END_256W;
                    2'h1:    bootEnd = code_space_pkg::BOOT_END_512W;
                    default: bootEnd = code_space_pkg::BOOT_END_1KW;
                endcase
            end
            // single bit selects 1K or 2K words
            default: bootEnd = f[0] ? code_space_pkg::BOOT_END_2KW
                                    : code_space_pkg::BOOT_END_1KW;
        endcase
    endfunction : bootEnd

    function automatic logic inRange(
        input logic [21:0] a,
        input logic [21:0] lo,
        input logic [21:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction : inRange

    // ------------------------------------------------------------------
    // table pointer bytes
    // ------------------------------------------------------------------
    logic [5:0]  ptrUpper;
    logic [7:0]  ptrHigh;
    logic [7:0]  ptrLow;
    logic        wrUpper;
    logic        wrHigh;
    logic        wrLow;
    logic [21:0] stepAmount;
    logic [21:0] next_ptr;

    // data RAM decode of the three bytes
    assign wrUpper = ramWrEn && (ramAddr == code_space_pkg::PTR_UPPER_OFS);
    assign wrHigh  = ramWrEn && (ramAddr == code_space_pkg::PTR_HIGH_OFS);
    assign wrLow   = ramWrEn && (ramAddr == code_space_pkg::PTR_LOW_OFS);
    assign ramHit  = (ramAddr == code_space_pkg::PTR_UPPER_OFS)
                  || (ramAddr == code_space_pkg::PTR_HIGH_OFS)
                  || (ramAddr == code_space_pkg::PTR_LOW_OFS);

    // 22-bit address from the three bytes
    assign tableAddr  = {ptrUpper, ptrHigh, ptrLow};
    assign stepAmount = ptrStepByTwo ? 22'h000002 : 22'h000001;

    always_comb begin
        next_ptr = tableAddr;
        if (ptrStepInc) begin
            next_ptr = tableAddr + stepAmount;
        end else if (ptrStepDec) begin
            next_ptr = tableAddr - stepAmount;
        end
    end

    // software writes win over a table-engine step in the written byte only; the other bytes still step
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ptrUpper <= code_space_pkg::PTR_BYTE_RESET[5:0];
            ptrHigh  <= code_space_pkg::PTR_BYTE_RESET;
            ptrLow   <= code_space_pkg::PTR_BYTE_RESET;
        end else begin
            ptrUpper <= wrUpper ? ramWrData[5:0] : next_ptr[21:16];
            ptrHigh  <= wrHigh  ? ramWrData      : next_ptr[15:8];
            ptrLow   <= wrLow   ? ramWrData      : next_ptr[7:0];
        end
    end

    // upper bits 7:6 read as zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ramRdData <= 8'h00;
        end else begin
            case (ramAddr)
                code_space_pkg::PTR_UPPER_OFS: ramRdData <= {2'h0, ptrUpper};
                code_space_pkg::PTR_HIGH_OFS:  ramRdData <= ptrHigh;
                code_space_pkg::PTR_LOW_OFS:   ramRdData <= ptrLow;
                default:                       ramRdData <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------------
    logic [21:0] curBootEnd;
    logic [21:0] curCodeEnd;
    logic [21:0] blockRaw;
    code_space_pkg::region_t next_region;

    assign curBootEnd = bootEnd(VARIANT, bootAreaSizeField);
    assign curCodeEnd = codeEnd(VARIANT);
    assign blockRaw   = tableAddr >> blockShift(VARIANT);

    always_comb begin
        next_region = code_space_pkg::REG_UNIMPL;
        if (tableAddr <= curBootEnd) begin
            next_region = code_space_pkg::REG_BOOT;
        // block 0 begins right after boot
        end else if (tableAddr <= curCodeEnd) begin
            next_region = code_space_pkg::REG_CODE;
        end else if (inRange(tableAddr, code_space_pkg::USER_ID_FIRST,
                             code_space_pkg::USER_ID_LAST)) begin
            next_region = code_space_pkg::REG_USER_ID;
        end else if (inRange(tableAddr, code_space_pkg::CONFIG_FIRST,
                             code_space_pkg::CONFIG_LAST)) begin
            next_region = code_space_pkg::REG_CONFIG;
        end else if (inRange(tableAddr, code_space_pkg::DEVICE_ID_FIRST,
                             code_space_pkg::DEVICE_ID_LAST)) begin
            next_region = code_space_pkg::REG_DEVICE_ID;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            region          <= code_space_pkg::REG_BOOT;
            blockIndex      <= 3'h0;
            protRegionValid <= 1'b1;
            readBypassProt  <= 1'b0;
            readOnlyArea    <= 1'b0;
        end else begin
            region          <= next_region;
            blockIndex      <= (next_region == code_space_pkg::REG_CODE)
                             ? blockRaw[2:0] : 3'h0;
            // protection applies per boot or block
            protRegionValid <= (next_region == code_space_pkg::REG_BOOT)
                            || (next_region == code_space_pkg::REG_CODE);
            readBypassProt  <= (next_region == code_space_pkg::REG_USER_ID)
                            || (next_region == code_space_pkg::REG_CONFIG)
                            || (next_region == code_space_pkg::REG_DEVICE_ID);
            readOnlyArea    <= (next_region == code_space_pkg::REG_DEVICE_ID);
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] syncPgc;
    logic [1:0] syncPgd;
    logic [1:0] syncVpp;
    logic [1:0] syncPgm;
    logic       pgcDelayed;
    logic       pgcFall;
    logic       progActive;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncPgc    <= 2'h0;
            syncPgd    <= 2'h0;
            syncVpp    <= 2'h0;
            syncPgm    <= 2'h0;
            pgcDelayed <= 1'b0;
        end else begin
            syncPgc    <= {syncPgc[0], programmingClock};
            syncPgd    <= {syncPgd[0], programmingData};
            syncVpp    <= {syncVpp[0], masterClearProgVoltage};
            syncPgm    <= {syncPgm[0], lowVoltageModeInput};
            pgcDelayed <= syncPgc[1];
        end
    end

    assign pgcFall    = pgcDelayed && !syncPgc[1];
    assign progActive = syncVpp[1];

    // mode pin honoured only with enable bit set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lowVoltageModeActive <= 1'b0;
        end else begin
            lowVoltageModeActive <= lowVoltageProgEnable && syncPgm[1];
        end
    end

    // ------------------------------------------------------------------
    // serial frame receiver
    // ------------------------------------------------------------------
    logic [4:0]  bitCount;
    logic [19:0] shiftReg;
    logic [19:0] shifted;

    assign shifted = {syncPgd[1], shiftReg[19:1]};

    // falling-edge latch, LSb first, 4 + 16 bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bitCount <= 5'h00;
            shiftReg <= 20'h00000;
        end else if (!progActive) begin
            bitCount <= 5'h00;
        end else if (pgcFall) begin
            shiftReg <= shifted;
            bitCount <= (bitCount == code_space_pkg::FRAME_LAST_BIT)
                      ? 5'h00 : bitCount + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frameValid     <= 1'b0;
            frameCmd       <= 4'h0;
            frameOperand   <= 16'h0000;
            coreInstrValid <= 1'b0;
        end else begin
            frameValid     <= 1'b0;
            coreInstrValid <= 1'b0;
            if (progActive && pgcFall
                && bitCount == code_space_pkg::FRAME_LAST_BIT) begin
                frameValid     <= 1'b1;
                frameCmd       <= shifted[3:0];
                frameOperand   <= shifted[19:4];
                // command 0 frames pulse coreInstrValid for one cycle
                coreInstrValid <= (shifted[3:0]
                                   == code_space_pkg::CMD_CORE_INSTR);
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence sLastFall;
        progActive && pgcFall && bitCount == code_space_pkg::FRAME_LAST_BIT;
    endsequence

    sequence sPulseOnce;
        frameValid ##1 !frameValid;
    endsequence

    chk_upper_write: assert property (
        wrUpper |=> tableAddr[21:16] == $past(ramWrData[5:0]))
        else $error("upper pointer byte write lost");

    chk_pointer_step: assert property (
        ptrStepInc && !ptrStepByTwo && !ramWrEn
        |=> tableAddr == $past(tableAddr) + 22'h000001)
        else $error("pointer increment wrong");

    chk_user_id_area: assert property (
        inRange(tableAddr, code_space_pkg::USER_ID_FIRST,
                code_space_pkg::USER_ID_LAST)
        |=> region == code_space_pkg::REG_USER_ID && readBypassProt)
        else $error("user ID address misdecoded");

    chk_config_area: assert property (
        inRange(tableAddr, code_space_pkg::CONFIG_FIRST,
                code_space_pkg::CONFIG_LAST)
        |=> region == code_space_pkg::REG_CONFIG && readBypassProt)
        else $error("configuration address misdecoded");

    chk_device_id_area: assert property (
        tableAddr >= code_space_pkg::DEVICE_ID_FIRST
        |=> region == code_space_pkg::REG_DEVICE_ID && readOnlyArea)
        else $error("device ID address misdecoded");

    chk_boot_area: assert property (
        tableAddr <= curBootEnd
        |=> region == code_space_pkg::REG_BOOT && protRegionValid)
        else $error("boot area misdecoded");

    chk_block_zero_start: assert property (
        tableAddr == curBootEnd + 22'h000001 && tableAddr <= curCodeEnd
        |=> region == code_space_pkg::REG_CODE && blockIndex == 3'h0)
        else $error("block 0 does not follow boot area");

    chk_unimpl_code: assert property (
        tableAddr > curCodeEnd && tableAddr < code_space_pkg::USER_ID_FIRST
        |=> region == code_space_pkg::REG_UNIMPL && !protRegionValid)
        else $error("unimplemented address not flagged");

    chk_low_voltage_gate: assert property (
        !lowVoltageProgEnable |=> !lowVoltageModeActive)
        else $error("mode pin honoured while disabled");

    chk_frame_end: assert property (
        sLastFall |=> sPulseOnce)
        else $error("frame pulse missing after last bit");

endmodule : code_space_region_decoder
